// ===== pkg/ledcfg_pkg.sv
// Constants, types and helpers shared by the LED driver register bank.
package ledcfg_pkg;
  // Register offsets on the serial bus.
  localparam logic [7:0] ADDR_CHIP_ID   = 8'h03;
  localparam logic [7:0] ADDR_DC_LEVEL  = 8'h07;
  localparam logic [7:0] ADDR_DRV_CFG   = 8'h08;
  localparam logic [7:0] ADDR_CH_EN     = 8'h09;
  localparam logic [7:0] ADDR_STAGGER   = 8'h0A;
  // Reset values.
  localparam logic [7:0] RST_DC_LEVEL   = 8'hFF;
  localparam logic [7:0] RST_DRV_CFG    = 8'h1F;
  localparam logic [5:0] RST_CH_EN      = 6'h3F;
  localparam logic [7:0] RST_STAGGER    = 8'h00;
  // Field positions.
  localparam int         CFG_SHORT_BIT  = 0;
  localparam int         CFG_FSW_BIT    = 2;
  localparam int         CFG_DRIVE_LSB  = 3;
  localparam int         STG_EVEN_BIT   = 7;
  localparam int         NUM_CH         = 6;
  // Identification; both values are arbitrary.
  localparam logic [3:0] MAKER_CODE     = 4'h5;
  localparam logic [3:0] MAKER_NONE     = 4'hF;
  localparam logic [3:0] MAKER_RSV_LO   = 4'hA;
  localparam logic [3:0] MAKER_RSV_HI   = 4'hE;
  localparam logic [2:0] SILICON_REV    = 3'h0;
  // Seven-bit bus address of this device.
  localparam logic [6:0] SLAVE_ADDR     = 7'h2C;
  // Timing of the stagger engine.
  localparam longint     REF_CLK_HZ     = 25_000_000;
  localparam longint     DIRECT_REF_HZ  = 12_800_000;
  localparam logic [7:0] PROG_DIV       = 8'hFF;

  typedef enum {
    LEDCF_IDLE, LEDCF_ADDR, LEDCF_ADDR_ACK, LEDCF_CMD, LEDCF_CMD_ACK,
    LEDCF_WDATA, LEDCF_WDATA_ACK, LEDCF_RDATA, LEDCF_RDATA_ACK
  } ledcf_state_e;

  function automatic logic [2:0] ledcf_count(input logic [5:0] m);
    logic [2:0] n;
    n = 3'h0;
    for (int i = 0; i < NUM_CH; i++) begin
      n = n + {2'h0, m[i]};
    end
    return n;
  endfunction
endpackage

// ===== design/ledcfg_smb_slave.sv
// Byte engine for the serial register bus: write byte and read byte.
`timescale 1ns/1ps
`default_nettype none
module ledcfg_smb_slave
  import ledcfg_pkg::*;
(
  // Clock and reset.
  input  wire logic       ref_clk_i,
  input  wire logic       rst_b_i,
  // Bus pins.
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_oe_o,
  // Register side.
  output logic [7:0]      reg_ptr_o,
  output logic            wr_stb_o,
  output logic [7:0]      wr_data_o,
  input  wire logic [7:0] rd_data_i
);
  logic [2:0]   scl_sq;
  logic [2:0]   sda_sq;
  logic         scl_rise;
  logic         scl_fall;
  logic         bus_start;
  logic         bus_stop;
  ledcf_state_e state_q;
  logic [3:0]   cnt_q;
  logic [7:0]   shift_q;
  logic         rw_q;
  logic         ack_q;

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      scl_sq <= 3'h7;
      sda_sq <= 3'h7;
    end else begin
      scl_sq <= {scl_sq[1:0], scl_i};
      sda_sq <= {sda_sq[1:0], sda_i};
    end
  end

  assign scl_rise  = scl_sq[1] & ~scl_sq[2];
  assign scl_fall  = ~scl_sq[1] & scl_sq[2];
  assign bus_start = scl_sq[1] & scl_sq[2] & ~sda_sq[1] & sda_sq[2];
  assign bus_stop  = scl_sq[1] & scl_sq[2] & sda_sq[1] & ~sda_sq[2];

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_q   <= LEDCF_IDLE;
      cnt_q     <= 4'h0;
      shift_q   <= 8'h00;
      rw_q      <= 1'b0;
      ack_q     <= 1'b0;
      sda_oe_o  <= 1'b0;
      reg_ptr_o <= 8'h00;
      wr_stb_o  <= 1'b0;
      wr_data_o <= 8'h00;
    end else begin
      wr_stb_o <= 1'b0;
      if (bus_start) begin
        state_q  <= LEDCF_ADDR;
        cnt_q    <= 4'h0;
        sda_oe_o <= 1'b0;
      end else if (bus_stop) begin
        state_q  <= LEDCF_IDLE;
        sda_oe_o <= 1'b0;
      end else if (scl_rise) begin
        case (state_q)
          LEDCF_ADDR, LEDCF_CMD, LEDCF_WDATA: begin
            shift_q <= {shift_q[6:0], sda_sq[1]};
            cnt_q   <= cnt_q + 4'h1;
          end
          LEDCF_RDATA:     cnt_q <= cnt_q + 4'h1;
          LEDCF_RDATA_ACK: ack_q <= ~sda_sq[1];
          default: ;
        endcase
      end else if (scl_fall) begin
        case (state_q)
          LEDCF_ADDR: if (cnt_q == 4'h8) begin
            rw_q <= shift_q[0];
            if (shift_q[7:1] == SLAVE_ADDR) begin
              state_q  <= LEDCF_ADDR_ACK;
              sda_oe_o <= 1'b1;
            end else begin
              state_q <= LEDCF_IDLE;
            end
          end
          LEDCF_CMD: if (cnt_q == 4'h8) begin
            reg_ptr_o <= shift_q;
            state_q   <= LEDCF_CMD_ACK;
            sda_oe_o  <= 1'b1;
          end
          LEDCF_WDATA: if (cnt_q == 4'h8) begin
            wr_data_o <= shift_q;
            wr_stb_o  <= 1'b1;
            state_q   <= LEDCF_WDATA_ACK;
            sda_oe_o  <= 1'b1;
          end
          LEDCF_ADDR_ACK: begin
            cnt_q <= 4'h0;
            if (rw_q) begin
              shift_q  <= rd_data_i;
              sda_oe_o <= ~rd_data_i[7];
              state_q  <= LEDCF_RDATA;
            end else begin
              sda_oe_o <= 1'b0;
              state_q  <= LEDCF_CMD;
            end
          end
          LEDCF_CMD_ACK, LEDCF_WDATA_ACK: begin
            cnt_q    <= 4'h0;
            sda_oe_o <= 1'b0;
            state_q  <= LEDCF_WDATA;
          end
          LEDCF_RDATA: begin
            if (cnt_q == 4'h8) begin
              sda_oe_o <= 1'b0;
              state_q  <= LEDCF_RDATA_ACK;
            end else begin
              shift_q  <= {shift_q[6:0], 1'b0};
              sda_oe_o <= ~shift_q[6];
            end
          end
          LEDCF_RDATA_ACK: begin
            cnt_q <= 4'h0;
            if (ack_q) begin
              shift_q  <= rd_data_i;
              sda_oe_o <= ~rd_data_i[7];
              state_q  <= LEDCF_RDATA;
            end else begin
              state_q <= LEDCF_IDLE;
            end
          end
          default: ;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ===== design/ledcfg_stagger.sv
// Per-channel PWM start staggering from the phase-control setting.
`timescale 1ns/1ps
`default_nettype none
module ledcfg_stagger
  import ledcfg_pkg::*;
(
  // Clock and reset.
  input  wire logic        ref_clk_i,
  input  wire logic        rst_b_i,
  // Settings.
  input  wire logic [5:0]  ch_on_i,
  input  wire logic        even_spread_i,
  input  wire logic [6:0]  stagger_amount_i,
  input  wire logic        direct_pwm_i,
  input  wire logic [15:0] pwm_period_i,
  // Results.
  output logic [15:0]      step_delay_o,
  output logic [5:0]       ch_start_o
);
  logic [15:0] pwm_cnt_q;
  logic [15:0] delay_d;
  logic [2:0]  n_on;
  logic [39:0] direct_t;
  logic [22:0] prog_t;

  assign n_on     = ledcf_count(ch_on_i);
  assign direct_t = 40'({33'h0, stagger_amount_i} * 40'(REF_CLK_HZ))
                    / 40'(DIRECT_REF_HZ);
  assign prog_t   = 23'({16'h0, stagger_amount_i} * {7'h0, pwm_period_i})
                    / 23'(PROG_DIV);

  always_comb begin
    if (direct_pwm_i) begin
      delay_d = direct_t[15:0];
    end else if (even_spread_i) begin
      delay_d = (n_on == 3'h0) ? 16'h0000
                : pwm_period_i / {13'h0, n_on};
    end else begin
      delay_d = prog_t[15:0];
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pwm_cnt_q    <= 16'h0000;
      step_delay_o <= 16'h0000;
    end else begin
      step_delay_o <= delay_d;
      pwm_cnt_q    <= (pwm_cnt_q + 16'h1 >= pwm_period_i) ? 16'h0000
                      : pwm_cnt_q + 16'h1;
    end
  end

  // A slot beyond the period never matches; the host keeps the spread short.
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ch_start_o <= 6'h00;
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        ch_start_o[i] <= ch_on_i[i] && ({3'h0, pwm_cnt_q} ==
          19'(ledcf_count(ch_on_i & 6'((1 << i) - 1)) * step_delay_o));
      end
    end
  end

  property p_even_delay;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      (even_spread_i && !direct_pwm_i && n_on != 3'h0)
      |=> step_delay_o == $past(pwm_period_i) / {13'h0, $past(n_on)};
  endproperty
  a_even_delay: assert property (p_even_delay)
    else $error("Even spread delay is not period over channel count.");

  property p_prog_delay;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      (!even_spread_i && !direct_pwm_i) |=> step_delay_o ==
        16'(({16'h0, $past(stagger_amount_i)} * {7'h0, $past(pwm_period_i)})
            / 23'h0000FF);
  endproperty
  a_prog_delay: assert property (p_prog_delay)
    else $error("Programmed delay is not setting times period over 255.");

  property p_direct_delay;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      (direct_pwm_i && stagger_amount_i == 7'h40) |=> step_delay_o == 16'd125;
  endproperty
  a_direct_delay: assert property (p_direct_delay)
    else $error("Direct mode delay does not follow the reference rate.");
endmodule
`default_nettype wire

// ===== design/ledcfg_regs.sv
// Register bank of the six-channel LED driver, reached over the serial bus.
//
// Notes on behaviour
// - Write byte to 0x07 sets DC level.
// - DC code is linear, applied while running.
// - Read byte at 0x07 returns DC level.
// - DC level resets to full, 0xFF.
// - ID: top bit one, maker, revision; read-only.
// - Maker codes 10-14 reserved; 15 means none.
// - Two drive bits pick 25/50/75/100 percent.
// - Config bit 2: 1200 kHz or 600 kHz.
// - Config bit 0 enables string short detection.
// - Config resets to 0x1F, all bits writable.
// - Mask bit i enables channel i.
// - Mask read shows only enabled healthy channels.
// - Clear then set retries a faulted channel.
// - Mask resets with all six channels on.
// - Even spread: period divided by enabled count.
// - Else delay is setting times period over 255.
// - Phase control resets to zero delay.
// - DC code scales on-time current, zero to full.
// - Direct PWM: setting over reference frequency.
`timescale 1ns/1ps
`default_nettype none
module ledcfg_regs
  import ledcfg_pkg::*;
(
  // Clock and reset.
  input  wire logic        ref_clk_i,
  input  wire logic        rst_b_i,
  // Serial bus pins; SDA is open drain.
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_o,
  // Channel fault detectors and PWM context.
  input  wire logic [5:0]  ch_fault_i,
  input  wire logic        direct_pwm_i,
  input  wire logic [15:0] pwm_period_i,
  // Analog controls.
  output logic [7:0]       dc_level_code_o,
  output logic [1:0]       fet_drive_strength_o,
  output logic [6:0]       fet_drive_pct_o,
  output logic             switch_freq_select_o,
  output logic             short_detect_enable_o,
  // Channel controls.
  output logic [5:0]       ch_on_o,
  output logic [5:0]       ch_start_o
);
  ////////////////////////////////////////////////////////////////////////////
  logic [7:0]  dc_level_q;
  logic [7:0]  drv_cfg_q;
  logic [5:0]  ch_en_q;
  logic [7:0]  stagger_q;
  logic [5:0]  fault_q;
  logic [5:0]  fault_s1_q;
  logic [5:0]  fault_s2_q;
  logic [5:0]  fault_set;
  logic [5:0]  fault_clr;
  logic [7:0]  reg_ptr;
  logic        wr_stb;
  logic [7:0]  wr_data;
  logic [7:0]  rd_data;
  logic [3:0]  maker_field;
  logic [5:0]  health;
  logic        sda_drv_q;

  function automatic logic wr_hit(input logic       stb,
                                  input logic [7:0] ptr,
                                  input logic [7:0] addr);
    return stb && (ptr == addr);
  endfunction

  function automatic logic [6:0] drive_pct(input logic [1:0] code);
    case (code)
      2'h0:    return 7'd25;
      2'h1:    return 7'd50;
      2'h2:    return 7'd75;
      default: return 7'd100;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  ledcfg_smb_slave u_slave (
    .ref_clk_i (ref_clk_i),
    .rst_b_i   (rst_b_i),
    .scl_i     (scl_i),
    .sda_i     (sda_i),
    .sda_oe_o  (sda_oe_o),
    .reg_ptr_o (reg_ptr),
    .wr_stb_o  (wr_stb),
    .wr_data_o (wr_data),
    .rd_data_i (rd_data)
  );

  // The open-drain pin only ever pulls low.
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sda_drv_q <= 1'b0;
    end else begin
      sda_drv_q <= 1'b0;
    end
  end
  assign sda_o = sda_drv_q;

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      dc_level_q <= RST_DC_LEVEL;
    end else if (wr_hit(wr_stb, reg_ptr, ADDR_DC_LEVEL)) begin
      dc_level_q <= wr_data;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      drv_cfg_q <= RST_DRV_CFG;
    end else if (wr_hit(wr_stb, reg_ptr, ADDR_DRV_CFG)) begin
      drv_cfg_q <= wr_data;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ch_en_q <= RST_CH_EN;
    end else if (wr_hit(wr_stb, reg_ptr, ADDR_CH_EN)) begin
      ch_en_q <= wr_data[5:0];
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      stagger_q <= RST_STAGGER;
    end else if (wr_hit(wr_stb, reg_ptr, ADDR_STAGGER)) begin
      stagger_q <= wr_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fault inputs come from the analog sinks and are synchronised first.
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      fault_s1_q <= 6'h00;
      fault_s2_q <= 6'h00;
    end else begin
      fault_s1_q <= ch_fault_i;
      fault_s2_q <= fault_s1_q;
    end
  end

  // A latched fault is dropped only by writing the channel's bit to zero;
  // a fault seen in the same cycle still wins so nothing is missed.
  assign fault_set = fault_s2_q & ch_en_q;
  assign fault_clr = wr_hit(wr_stb, reg_ptr, ADDR_CH_EN) ?
                     ~wr_data[5:0] : 6'h00;

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      fault_q <= 6'h00;
    end else begin
      fault_q <= (fault_q & ~fault_clr) | fault_set;
    end
  end

  assign health = ch_en_q & ~fault_q;

  ////////////////////////////////////////////////////////////////////////////
  // A reserved maker code is never reported; it reads as not implemented.
  assign maker_field = (MAKER_CODE >= MAKER_RSV_LO &&
                        MAKER_CODE <= MAKER_RSV_HI) ? MAKER_NONE
                       : MAKER_CODE;

  always_comb begin
    case (reg_ptr)
      ADDR_CHIP_ID:  rd_data = {1'b1, maker_field, SILICON_REV};
      ADDR_DC_LEVEL: rd_data = dc_level_q;
      ADDR_DRV_CFG:  rd_data = drv_cfg_q;
      ADDR_CH_EN:    rd_data = {2'h0, health};
      ADDR_STAGGER:  rd_data = stagger_q;
      default:       rd_data = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs are registered copies, so a new code takes effect on the fly.
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      dc_level_code_o       <= RST_DC_LEVEL;
      fet_drive_strength_o  <= RST_DRV_CFG[CFG_DRIVE_LSB +: 2];
      fet_drive_pct_o       <= 7'd100;
      switch_freq_select_o  <= RST_DRV_CFG[CFG_FSW_BIT];
      short_detect_enable_o <= RST_DRV_CFG[CFG_SHORT_BIT];
      ch_on_o               <= 6'h00;
    end else begin
      dc_level_code_o       <= dc_level_q;
      fet_drive_strength_o  <= drv_cfg_q[CFG_DRIVE_LSB +: 2];
      fet_drive_pct_o       <= drive_pct(drv_cfg_q[CFG_DRIVE_LSB +: 2]);
      switch_freq_select_o  <= drv_cfg_q[CFG_FSW_BIT];
      short_detect_enable_o <= drv_cfg_q[CFG_SHORT_BIT];
      ch_on_o               <= health;
    end
  end

  ledcfg_stagger u_stagger (
    .ref_clk_i        (ref_clk_i),
    .rst_b_i          (rst_b_i),
    .ch_on_i          (health),
    .even_spread_i    (stagger_q[STG_EVEN_BIT]),
    .stagger_amount_i (stagger_q[6:0]),
    .direct_pwm_i     (direct_pwm_i),
    .pwm_period_i     (pwm_period_i),
    .step_delay_o     (),
    .ch_start_o       (ch_start_o)
  );

  ////////////////////////////////////////////////////////////////////////////
  sequence s_cfg_write;
    wr_stb && reg_ptr == ADDR_DRV_CFG;
  endsequence

  sequence s_cfg_applied;
    ##2 (switch_freq_select_o == $past(wr_data[CFG_FSW_BIT], 2)) &&
        (short_detect_enable_o == $past(wr_data[CFG_SHORT_BIT], 2));
  endsequence

  property p_dc_write;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      (wr_stb && reg_ptr == ADDR_DC_LEVEL) |=> ##1
        dc_level_code_o == $past(wr_data, 2);
  endproperty
  a_dc_write: assert property (p_dc_write)
    else $error("DC level output does not follow its write.");

  property p_dc_read;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      reg_ptr == ADDR_DC_LEVEL |-> rd_data == dc_level_q;
  endproperty
  a_dc_read: assert property (p_dc_read)
    else $error("DC level readback differs from stored level.");

  property p_id_read;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      reg_ptr == ADDR_CHIP_ID |-> rd_data[7] && rd_data[2:0] == SILICON_REV
        && !(rd_data[6:3] inside {[4'hA:4'hE]});
  endproperty
  a_id_read: assert property (p_id_read)
    else $error("Identification readback is malformed.");

  property p_cfg_write;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      s_cfg_write |-> s_cfg_applied;
  endproperty
  a_cfg_write: assert property (p_cfg_write)
    else $error("Configuration write did not reach its outputs.");

  property p_drive_pct;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      ##1 fet_drive_pct_o == 7'(25 * (32'(fet_drive_strength_o) + 1));
  endproperty
  a_drive_pct: assert property (p_drive_pct)
    else $error("Drive strength percentage mismatch.");

  property p_health_read;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      reg_ptr == ADDR_CH_EN |->
        rd_data == {2'h0, ch_en_q & ~fault_q};
  endproperty
  a_health_read: assert property (p_health_read)
    else $error("Channel readback shows a disabled or faulted channel.");

  property p_retry;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      (wr_stb && reg_ptr == ADDR_CH_EN) |=>
        (fault_q & ~$past(wr_data[5:0]) & ~$past(fault_set)) == 6'h00;
  endproperty
  a_retry: assert property (p_retry)
    else $error("Disabling a channel did not clear its fault.");

  property p_fault_off;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      (|fault_set) |=> ##1 (ch_on_o & $past(fault_set, 2)) == 6'h00;
  endproperty
  a_fault_off: assert property (p_fault_off)
    else $error("Faulted channel was left running.");

  // A channel switched off in the mask must leave the outputs two cycles
  // later, whatever its fault latch holds.
  property p_mask_write;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      (wr_stb && reg_ptr == ADDR_CH_EN) |=> ##1
        (ch_on_o & ~$past(wr_data[5:0], 2)) == 6'h00;
  endproperty
  a_mask_write: assert property (p_mask_write)
    else $error("Disabled channel was left running.");

  // Only enabled healthy channels may open a PWM cycle.
  property p_start_gate;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      (ch_start_o & ~$past(health)) == 6'h00;
  endproperty
  a_start_gate: assert property (p_start_gate)
    else $error("Start pulse on a disabled or faulted channel.");
endmodule
`default_nettype wire

// ===== sim/ledcfg_host.sv
// Bus host model that bit-bangs write byte and read byte cycles.
`timescale 1ns/1ps
`default_nettype none
module ledcfg_host (
  // Clock.
  input  wire logic ref_clk_i,
  // Bus wires.
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_pull_o
);
  initial begin
    scl_o = 1'b1;
    sda_pull_o = 1'b0;
  end
  ////////////////////////////////////////////////////////////
  task automatic tk(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask
  // Data moves a clock after SCL falls, so no false start is seen.
  task automatic bit_io(input logic b, output logic r);
    tk(1);
    sda_pull_o <= ~b;
    tk(3);
    scl_o <= 1'b1;
    tk(4);
    r = sda_i;
    scl_o <= 1'b0;
  endtask
  task automatic frame(input logic stop);
    tk(1);
    sda_pull_o <= stop;
    tk(3);
    scl_o <= 1'b1;
    tk(4);
    sda_pull_o <= ~stop;
    tk(4);
    if (!stop) scl_o <= 1'b0;
  endtask
  task automatic byte_io(input logic [7:0] d, output logic [7:0] q,
                         output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
      q[i] = r;
    end
    bit_io(1'b1, r);
    ack = ~r;
  endtask
  // A read always ends with a not-acknowledge from the host.
  task automatic xfer(input logic [6:0] sa, input logic rd,
                      input logic [7:0] ptr, inout logic [7:0] d,
                      output logic ok);
    logic [7:0] q;
    logic       a0;
    logic       a1;
    logic       a2;
    logic       a3;
    frame(1'b0);
    byte_io({sa, 1'b0}, q, a0);
    byte_io(ptr, q, a1);
    a2 = 1'b1;
    if (rd) begin
      frame(1'b0);
      byte_io({sa, 1'b1}, q, a2);
    end
    byte_io(rd ? 8'hFF : d, q, a3);
    frame(1'b1);
    if (rd) d = q;
    ok = a0 & a1 & a2 & (rd | a3);
  endtask
endmodule
`default_nettype wire

// ===== sim/ledcfg_regs_test.sv
// Self-checking bench of the LED driver register bank.
`timescale 1ns/1ps
`default_nettype none
module ledcfg_regs_test;
  import ledcfg_pkg::*;
  logic        ref_clk_i;
  logic        rst_b_i;
  logic        scl;
  logic        pull;
  logic        sda_o;
  logic        sda_oe_o;
  logic        direct_pwm;
  logic [5:0]  ch_fault;
  logic [15:0] pwm_period;
  logic [7:0]  dc_level;
  logic [1:0]  drive;
  logic [6:0]  pct;
  logic        switch_freq_select;
  logic        sc_en;
  logic [5:0]  ch_on;
  logic [5:0]  ch_start;
  wire         sda = ~pull & ~(sda_oe_o & ~sda_o);
  logic [15:0] exp_q[$];
  logic [15:0] got_q[$];
  int          fail_count = 0;
  int          tests_run = 0;
  logic [31:0] seed = 32'h7A6A;

  ledcfg_host ledcfg_host_i (.ref_clk_i(ref_clk_i), .sda_i(sda),
    .scl_o(scl), .sda_pull_o(pull));
  ledcfg_regs ledcfg_regs_i (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
    .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
    .ch_fault_i(ch_fault), .direct_pwm_i(direct_pwm),
    .pwm_period_i(pwm_period), .dc_level_code_o(dc_level),
    .fet_drive_strength_o(drive), .fet_drive_pct_o(pct),
    .switch_freq_select_o(switch_freq_select), .short_detect_enable_o(sc_en),
    .ch_on_o(ch_on), .ch_start_o(ch_start));
  ////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic note(input logic [15:0] e, input logic [15:0] g);
    exp_q.push_back(e);
    got_q.push_back(g);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] v;
    logic       ok;
    v = d;
    ledcfg_host_i.xfer(SLAVE_ADDR, 1'b0, a, v, ok);
    note(16'h0001, {15'h0, ok});
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] v;
    logic       ok;
    exp_q.push_back({8'h0, e});
    ledcfg_host_i.xfer(SLAVE_ADDR, 1'b1, a, v, ok);
    got_q.push_back(ok ? {8'h0, v} : 16'hDEAD);
  endtask
  // Counts clocks from the start pulse of channel a to that of b.
  // Pulses are looked at on the falling edge, away from their launch edge.
  task automatic gap(input int a, input int b, input int e);
    int n;
    n = 0;
    @(negedge ref_clk_i);
    while (ch_start[a] !== 1'b1 && n < 4000) begin
      @(negedge ref_clk_i);
      n++;
    end
    n = 0;
    do begin
      @(negedge ref_clk_i);
      n++;
    end while (ch_start[b] !== 1'b1 && n < 4000);
    if (n >= 4000) begin
      fail_count++;
      $display("MISMATCH t=%0t start pulse missing", $time);
      summarize();
    end
    note(e[15:0], n[15:0]);
    @(posedge ref_clk_i);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    ref_clk_i = 1'b0;
    forever #20 ref_clk_i = ~ref_clk_i;
  end
  initial begin
    forever begin
      wait (got_q.size() > 0);
      tests_run++;
      if (got_q[0] !== exp_q[0]) begin
        fail_count++;
        $display("MISMATCH t=%0t got %h exp %h", $time, got_q[0],
                 exp_q[0]);
      end
      void'(got_q.pop_front());
      void'(exp_q.pop_front());
    end
  end
  initial begin
    logic [7:0] v;
    logic       ok;
    rst_b_i = 1'b0;
    ch_fault = 6'h00;
    direct_pwm = 1'b0;
    pwm_period = 16'h0064;
    repeat (2) @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    note({ch_on, switch_freq_select, sc_en, drive, 6'h0}, 16'hFFC0);
    note({9'h0, pct}, 16'h0064);
    rd(ADDR_DC_LEVEL, RST_DC_LEVEL);
    rd(ADDR_DRV_CFG, RST_DRV_CFG);
    rd(ADDR_CH_EN, {2'h0, RST_CH_EN});
    rd(ADDR_STAGGER, 8'h00);
    for (int i = 0; i < 3; i++) begin
      v = (i == 0) ? 8'h00 : 8'(rnd());
      wr(ADDR_DC_LEVEL, v);
      note({8'h0, dc_level}, {8'h0, v});
      rd(ADDR_DC_LEVEL, v);
    end
    ok = 1'b1;
    v = ~v;
    ledcfg_host_i.xfer(SLAVE_ADDR ^ 7'h01, 1'b0, ADDR_DC_LEVEL, v, ok);
    v = ~v;
    note({15'h0, ok}, 16'h0000);
    note({8'h0, dc_level}, {8'h0, v});
    for (int k = 0; k < 4; k++) begin
      v = 8'(rnd());
      v[4:3] = k[1:0];
      v[2] = k[0];
      v[0] = k[1];
      wr(ADDR_DRV_CFG, v);
      note({5'h0, drive, switch_freq_select, sc_en, pct},
           {5'h0, v[4:3], v[2], v[0], 7'(25 * (k + 1))});
      rd(ADDR_DRV_CFG, v);
    end
    wr(ADDR_CHIP_ID, 8'h00);
    rd(ADDR_CHIP_ID, {1'b1, MAKER_CODE, SILICON_REV});
    rd(8'h05, 8'h00);
    wr(ADDR_CH_EN, 8'hD5);
    note({10'h0, ch_on}, 16'h0015);
    ch_fault <= 6'h04;
    repeat (8) @(posedge ref_clk_i);
    rd(ADDR_CH_EN, 8'h11);
    note({10'h0, ch_on}, 16'h0011);
    ch_fault <= 6'h00;
    wr(ADDR_CH_EN, 8'h11);
    wr(ADDR_CH_EN, 8'h15);
    rd(ADDR_CH_EN, 8'h15);
    wr(ADDR_CH_EN, 8'h0F);
    wr(ADDR_STAGGER, 8'h80);
    gap(1, 3, 50);
    // Spread of three steps of 20 stays within the period of 100.
    wr(ADDR_STAGGER, 8'h33);
    gap(0, 1, 20);
    direct_pwm <= 1'b1;
    pwm_period <= 16'h03E8;
    wr(ADDR_STAGGER, 8'h40);
    gap(0, 2, 250);
    repeat (2) @(posedge ref_clk_i);
    summarize();
  end
endmodule
`default_nettype wire
